//--- inc/bridge_ctrl_pkg.sv
// constants and types for the dual bridge stepper control core
// assumes a 25 MHz core clock; times are converted to cycle counts here
package bridge_ctrl_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int DEAD_TIME_NS = 450;
    localparam int OFF_TIME_US = 23;
    localparam int FILTER_TIME_US = 1;
    localparam int RETRY_TIME_US = 1400;
    localparam int WAKE_DELAY_US = 155;
    localparam int SLEEP_ENTRY_US = 10;
    localparam int BLANK_CYCLES_DEF = 25;
    // least times round up, longest round down
    localparam int DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int OFF_CYC = OFF_TIME_US * CLK_MHZ;
    localparam int FILTER_CYC = FILTER_TIME_US * CLK_MHZ;
    localparam int RETRY_CYC = RETRY_TIME_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_DELAY_US * CLK_MHZ;
    localparam int SLEEP_CYC = SLEEP_ENTRY_US * CLK_MHZ;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CLEAR = 4'h4;
    localparam logic [3:0] ADDR_ENABLE = 4'h8;
    localparam logic [3:0] ADDR_STATE = 4'hc;
    localparam int EVT_W = 5;
    // event bit positions
    localparam int EVT_CHOP_A = 0;
    localparam int EVT_CHOP_B = 1;
    localparam int EVT_OC_A = 2;
    localparam int EVT_OC_B = 3;
    localparam int EVT_TEMP = 4;
    localparam logic [EVT_W-1:0] ENABLE_RST = 5'h00;

    // ------------------------------------------------------------
    // power sequencing states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_SLEEP = 2'b00,
        PWR_WAKE = 2'b01,
        PWR_RUN = 2'b10,
        PWR_ENTER = 2'b11
    } pwr_state_t;

endpackage

//--- core/bridge_ctrl.sv
// dual full-bridge stepper control core with wishbone status/interrupt regs
// assumes analog comparators and protection flags arrive asynchronously
`timescale 1ns/100ps
module bridge_ctrl
    import bridge_ctrl_pkg::*;
#(
    parameter int BLANK_CYCLES = BLANK_CYCLES_DEF,
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int OFF_CYCLES = OFF_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // bridge control pins, asynchronous
    input wire logic bridge_a_ctrl_first_i,
    input wire logic bridge_a_ctrl_second_i,
    input wire logic bridge_b_ctrl_first_i,
    input wire logic bridge_b_ctrl_second_i,
    input wire logic sleep_request_low_i,
    // analog indications, asynchronous
    input wire logic [1:0] current_sense_trip_i,
    input wire logic [1:0] overcurrent_high_i,
    input wire logic [1:0] overcurrent_low_i,
    input wire logic over_temp_i,
    input wire logic supply_low_lockout_i,
    // gate drives per bridge: bit 0 first leg, bit 1 second leg
    output logic [1:0] bridge_a_high_on_o,
    output logic [1:0] bridge_a_low_on_o,
    output logic [1:0] bridge_b_high_on_o,
    output logic [1:0] bridge_b_low_on_o,
    // open-drain fault pin
    output logic fault_flag_low_o,
    output logic fault_flag_low_oe_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SYN_W = 13;
    logic [SYN_W-1:0] raw_in, sync1_q, sync2_q;
    assign raw_in = {supply_low_lockout_i, over_temp_i, overcurrent_low_i, overcurrent_high_i,
                     current_sense_trip_i, sleep_request_low_i, bridge_b_ctrl_second_i,
                     bridge_b_ctrl_first_i, bridge_a_ctrl_second_i, bridge_a_ctrl_first_i};
    // two stages before any logic looks at a pin
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    logic [1:0] in_first, in_second, sense_s, oc_any_s;
    logic sleep_low_s, temp_s, supply_low_lockout_s;
    assign in_first = {sync2_q[2], sync2_q[0]};
    assign in_second = {sync2_q[3], sync2_q[1]};
    assign sleep_low_s = sync2_q[4];
    assign sense_s = sync2_q[6:5];
    assign oc_any_s = sync2_q[8:7] | sync2_q[10:9];
    assign temp_s = sync2_q[11];
    assign supply_low_lockout_s = sync2_q[12];

    // ------------------------------------------------------------
    // sleep and wake sequencing
    // ------------------------------------------------------------
    pwr_state_t pwr_q;
    logic [CNT_W-1:0] pwr_cnt_q;
    // entry and wake counts both fit in 16 bits
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pwr_q <= PWR_SLEEP;
            pwr_cnt_q <= '0;
        end else if (supply_low_lockout_s) begin
            pwr_q <= PWR_SLEEP;
            pwr_cnt_q <= '0;
        end else begin
            unique case (pwr_q)
                PWR_SLEEP: begin
                    pwr_cnt_q <= '0;
                    if (sleep_low_s) begin
                        pwr_q <= PWR_WAKE;
                    end
                end
                PWR_WAKE: begin
                    if (!sleep_low_s) begin
                        pwr_q <= PWR_SLEEP;
                    end else if (pwr_cnt_q == CNT_W'(WAKE_CYCLES - 1)) begin
                        pwr_q <= PWR_RUN;
                        pwr_cnt_q <= '0;
                    end else begin
                        pwr_cnt_q <= pwr_cnt_q + 1'b1;
                    end
                end
                PWR_RUN: begin
                    pwr_cnt_q <= '0;
                    if (!sleep_low_s) begin
                        pwr_q <= PWR_ENTER;
                    end
                end
                PWR_ENTER: begin
                    // bridges already off; full reset follows within entry time
                    if (pwr_cnt_q == CNT_W'(SLEEP_CYC - 1)) begin
                        pwr_q <= PWR_SLEEP;
                    end else begin
                        pwr_cnt_q <= pwr_cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // internal logic held reset while not running
    logic run, core_clr;
    assign run = (pwr_q == PWR_RUN) && !supply_low_lockout_s;
    assign core_clr = !run;

    // ------------------------------------------------------------
    // per bridge logic
    // ------------------------------------------------------------
    logic [1:0] oc_shut;
    logic [1:0] chop_evt;
    logic [1:0] oc_evt;
    logic [1:0] high_on [2];
    logic [1:0] low_on [2];

    for (genvar b = 0; b < 2; b++) begin : g_bridge
        logic [1:0] want_high, want_low;
        logic drive_act, chop_q, shut_q;
        logic [CNT_W-1:0] off_cnt_q, blank_cnt_q, oc_cnt_q;
        logic [20:0] retry_cnt_q;
        logic [1:0] high_q, low_q, dead_q;
        logic [CNT_W-1:0] dead_cnt_q [2];

        // decode this bridge's own pair only
        always_comb begin
            want_high = 2'b00;
            want_low = 2'b00;
            drive_act = 1'b0;
            if (shut_q) begin
                want_high = 2'b00;
            end else if (chop_q) begin
                want_low = 2'b11;
            end else begin
                unique case ({in_first[b], in_second[b]})
                    2'b00: want_high = 2'b00;
                    2'b01: begin
                        want_low = 2'b01;
                        want_high = 2'b10;
                        drive_act = 1'b1;
                    end
                    2'b10: begin
                        want_high = 2'b01;
                        want_low = 2'b10;
                        drive_act = 1'b1;
                    end
                    2'b11: want_low = 2'b11;
                endcase
            end
        end

        // blanking counts from each start of drive current
        always_ff @(posedge mclk_i or posedge reset_i) begin
            if (reset_i) begin
                blank_cnt_q <= '0;
            end else if (core_clr || !drive_act) begin
                blank_cnt_q <= '0;
            end else if (blank_cnt_q != CNT_W'(BLANK_CYCLES)) begin
                blank_cnt_q <= blank_cnt_q + 1'b1;
            end
        end

        // fixed off-time slow decay after a sense trip
        always_ff @(posedge mclk_i or posedge reset_i) begin
            if (reset_i) begin
                chop_q <= 1'b0;
                off_cnt_q <= '0;
            end else if (core_clr) begin
                chop_q <= 1'b0;
                off_cnt_q <= '0;
            end else if (chop_q) begin
                if (off_cnt_q == CNT_W'(OFF_CYCLES - 1)) begin
                    chop_q <= 1'b0;
                    off_cnt_q <= '0;
                end else begin
                    off_cnt_q <= off_cnt_q + 1'b1;
                end
            end else if (drive_act && sense_s[b] && blank_cnt_q == CNT_W'(BLANK_CYCLES)) begin
                chop_q <= 1'b1;
            end
        end
        assign chop_evt[b] = !core_clr && !chop_q && drive_act && sense_s[b]
                             && blank_cnt_q == CNT_W'(BLANK_CYCLES);

        // overcurrent filter, then timed retry while it persists
        always_ff @(posedge mclk_i or posedge reset_i) begin
            if (reset_i) begin
                oc_cnt_q <= '0;
                retry_cnt_q <= '0;
                shut_q <= 1'b0;
            end else if (core_clr) begin
                oc_cnt_q <= '0;
                retry_cnt_q <= '0;
                shut_q <= 1'b0;
            end else if (shut_q) begin
                oc_cnt_q <= '0;
                if (retry_cnt_q == 21'(RETRY_CYCLES - 1)) begin
                    shut_q <= 1'b0;
                    retry_cnt_q <= '0;
                end else begin
                    retry_cnt_q <= retry_cnt_q + 1'b1;
                end
            end else if (!oc_any_s[b]) begin
                oc_cnt_q <= '0;
            end else if (oc_cnt_q == CNT_W'(FILTER_CYC)) begin
                shut_q <= 1'b1;
                oc_cnt_q <= '0;
            end else begin
                oc_cnt_q <= oc_cnt_q + 1'b1;
            end
        end
        assign oc_shut[b] = shut_q;
        assign oc_evt[b] = !core_clr && !shut_q && oc_any_s[b] && oc_cnt_q == CNT_W'(FILTER_CYC);

        // dead time per leg: a switch on waits after its partner turns off
        for (genvar l = 0; l < 2; l++) begin : g_leg
            logic go_high, go_low;
            assign go_high = want_high[l] && !temp_s;
            assign go_low = want_low[l] && !temp_s;
            always_ff @(posedge mclk_i or posedge reset_i) begin
                if (reset_i) begin
                    high_q[l] <= 1'b0;
                    low_q[l] <= 1'b0;
                    dead_q[l] <= 1'b0;
                    dead_cnt_q[l] <= '0;
                end else if (core_clr) begin
                    high_q[l] <= 1'b0;
                    low_q[l] <= 1'b0;
                    dead_q[l] <= 1'b0;
                    dead_cnt_q[l] <= '0;
                end else if ((high_q[l] && !go_high) || (low_q[l] && !go_low)) begin
                    // turn-offs are immediate; gap starts now
                    high_q[l] <= high_q[l] & go_high;
                    low_q[l] <= low_q[l] & go_low;
                    dead_q[l] <= 1'b1;
                    dead_cnt_q[l] <= '0;
                end else if (dead_q[l]) begin
                    if (dead_cnt_q[l] == CNT_W'(DEAD_CYC - 1)) begin
                        dead_q[l] <= 1'b0;
                    end else begin
                        dead_cnt_q[l] <= dead_cnt_q[l] + 1'b1;
                    end
                end else begin
                    high_q[l] <= go_high && !low_q[l];
                    low_q[l] <= go_low && !high_q[l];
                end
            end
        end
        assign high_on[b] = high_q;
        assign low_on[b] = low_q;
    end

    assign bridge_a_high_on_o = high_on[0];
    assign bridge_a_low_on_o = low_on[0];
    assign bridge_b_high_on_o = high_on[1];
    assign bridge_b_low_on_o = low_on[1];

    // ------------------------------------------------------------
    // fault pin
    // ------------------------------------------------------------
    logic fault_q;
    // undervoltage and sleep clear the shutdowns, so no report then
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= run && (temp_s || |oc_shut);
        end
    end
    assign fault_flag_low_o = 1'b0;
    assign fault_flag_low_oe_o = fault_q;

    // ------------------------------------------------------------
    // event status, clear, enable and wishbone slave
    // ------------------------------------------------------------
    logic [EVT_W-1:0] status_q, enable_q, evt;
    logic temp_d1_q, wb_req, wb_wr;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            temp_d1_q <= 1'b0;
        end else begin
            temp_d1_q <= temp_s;
        end
    end
    assign evt = {temp_s && !temp_d1_q, oc_evt, chop_evt};
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            status_q <= '0;
        end else if (wb_wr && wb_adr_i == ADDR_CLEAR) begin
            status_q <= (status_q & ~wb_dat_i[EVT_W-1:0]) | evt;
        end else begin
            status_q <= status_q | evt;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            enable_q <= ENABLE_RST;
        end else if (wb_wr && wb_adr_i == ADDR_ENABLE) begin
            enable_q <= wb_dat_i[EVT_W-1:0];
        end
    end

    // ack on the edge after the request is seen
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= '0;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    ADDR_STATUS: wb_dat_o <= 32'(status_q);
                    ADDR_ENABLE: wb_dat_o <= 32'(enable_q);
                    ADDR_STATE: wb_dat_o <= 32'({oc_shut, fault_q, pwr_q});
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_q & enable_q);
        end
    end

endmodule

//--- tb/bridge_ctrl_asserts.sv
// checker for the bridge control core, bound to its top ports
// assumes one clock domain and a high active async reset
`timescale 1ns/100ps
module bridge_ctrl_asserts
    import bridge_ctrl_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // watched inputs
    input wire logic sleep_request_low_i,
    input wire logic [1:0] overcurrent_high_i,
    input wire logic [1:0] overcurrent_low_i,
    input wire logic over_temp_i,
    input wire logic supply_low_lockout_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    // watched outputs
    input wire logic [1:0] bridge_a_high_on_o,
    input wire logic [1:0] bridge_a_low_on_o,
    input wire logic [1:0] bridge_b_high_on_o,
    input wire logic [1:0] bridge_b_low_on_o,
    input wire logic fault_flag_low_o,
    input wire logic fault_flag_low_oe_o,
    input wire logic wb_ack_o
);
    logic [7:0] off_cnt_q;
    logic [7:0] ind_q;
    logic gates_off;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // all gates of both bridges off
    assign gates_off = ~|{bridge_a_high_on_o, bridge_a_low_on_o, bridge_b_high_on_o, bridge_b_low_on_o};
    // idle cycles of the first high gate; reset reads as long idle
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            off_cnt_q <= 8'hff;
        end else if (bridge_a_high_on_o[0]) begin
            off_cnt_q <= 8'h00;
        end else if (off_cnt_q != 8'hff) begin
            off_cnt_q <= off_cnt_q + 8'h01;
        end
    end
    // recent raw fault indications
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ind_q <= 8'h00;
        end else begin
            ind_q <= {ind_q[6:0], over_temp_i | (|overcurrent_high_i) | (|overcurrent_low_i)};
        end
    end
    AST_NO_SHOOT: assert property (
        ((bridge_a_high_on_o & bridge_a_low_on_o) | (bridge_b_high_on_o & bridge_b_low_on_o)) == 2'b00)
        else $error("both gates of one leg on");
    AST_DEAD_GAP: assert property (
        $rose(bridge_a_low_on_o[0]) |-> off_cnt_q >= DEAD_CYC)
        else $error("low gate on before dead gap ended");
    AST_SLEEP_OFF: assert property (
        !sleep_request_low_i [*5] |-> gates_off)
        else $error("gates on during sleep request");
    AST_WAKE_HOLD: assert property (
        $rose(sleep_request_low_i) |-> gates_off [*8])
        else $error("gates on before wake delay");
    AST_SUPPLY_OFF: assert property (
        supply_low_lockout_i [*5] |-> gates_off && !fault_flag_low_oe_o)
        else $error("undervoltage left gates or fault on");
    AST_TEMP_OFF: assert property (
        over_temp_i [*5] |-> gates_off)
        else $error("gates on during over temperature");
    AST_FAULT_CAUSE: assert property (
        $rose(fault_flag_low_oe_o) |-> |ind_q)
        else $error("fault flag without indication");
    AST_FAULT_DATA: assert property (
        fault_flag_low_o == 1'b0)
        else $error("open drain data not low");
    AST_ACK_PULSE: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one cycle answer");
    COV_ACK: cover property (wb_ack_o);
    COV_FAULT: cover property ($rose(fault_flag_low_oe_o));
    COV_DECAY: cover property (bridge_a_low_on_o == 2'b11);
endmodule

//--- tb/pwm_source.sv
// controller model driving the two bridge input pairs
// assumes the bench sets levels by nba at rising edges
`timescale 1ns/100ps
module pwm_source #(
    parameter int HALF = 40
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // held levels, bit1 first input, bit0 second
    input wire logic [1:0] lvl_a_i,
    input wire logic [1:0] lvl_b_i,
    // chop pair a; sel 1 pulses first input, 0 second
    input wire logic pwm_en_i,
    input wire logic pwm_sel_i,
    // bridge input pins
    output logic a_first_o,
    output logic a_second_o,
    output logic b_first_o,
    output logic b_second_o
);
    logic [7:0] ph_q;
    logic on_q;
    // edges land on clock edges, as a real timer's would
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ph_q <= 8'h00;
            on_q <= 1'b0;
        end else if (ph_q == 8'(HALF - 1)) begin
            ph_q <= 8'h00;
            on_q <= ~on_q;
        end else begin
            ph_q <= ph_q + 8'h01;
        end
    end
    // held level picks the decay, 0 coast, 1 brake; the pulsed input gives direction only when the held one is 0
    assign a_first_o = (pwm_en_i && pwm_sel_i) ? on_q : lvl_a_i[1];
    assign a_second_o = (pwm_en_i && !pwm_sel_i) ? on_q : lvl_a_i[0];
    assign b_first_o = lvl_b_i[1];
    assign b_second_o = lvl_b_i[0];
endmodule

//--- tb/testbench.sv
// self-checking bench for the dual bridge control core
// assumes the controller model drives the input pairs
`timescale 1ns/100ps
module testbench;
    import bridge_ctrl_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] lvl_a = 2'b00, lvl_b = 2'b00, sense = 2'b00, oc_hi = 2'b00, oc_lo = 2'b00;
    logic pwm_en = 1'b0, pwm_sel = 1'b0, temp = 1'b0, supply_low = 1'b0, sleep_request_low = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0, wb_sel = 4'he;
    logic [31:0] wb_dat = 32'h0;
    logic a1, a2, b1, b2, flt, flt_oe, ack, irq;
    logic [1:0] ah, al, bh, bl;
    logic [31:0] rdat, q;
    int err_count = 0;
    int n_compared = 0;
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    pwm_source pwm_source_inst (.mclk_i(mclk_i), .reset_i(reset_i), .lvl_a_i(lvl_a),
        .lvl_b_i(lvl_b), .pwm_en_i(pwm_en), .pwm_sel_i(pwm_sel), .a_first_o(a1), .a_second_o(a2),
        .b_first_o(b1), .b_second_o(b2));
    // short counts keep the run brief
    bridge_ctrl #(.BLANK_CYCLES(10), .RETRY_CYCLES(100), .OFF_CYCLES(20), .WAKE_CYCLES(20)) bridge_ctrl_inst (
        .mclk_i(mclk_i), .reset_i(reset_i), .bridge_a_ctrl_first_i(a1), .bridge_a_ctrl_second_i(a2),
        .bridge_b_ctrl_first_i(b1), .bridge_b_ctrl_second_i(b2), .sleep_request_low_i(sleep_request_low),
        .current_sense_trip_i(sense), .overcurrent_high_i(oc_hi), .overcurrent_low_i(oc_lo),
        .over_temp_i(temp), .supply_low_lockout_i(supply_low), .bridge_a_high_on_o(ah), .bridge_a_low_on_o(al),
        .bridge_b_high_on_o(bh), .bridge_b_low_on_o(bl), .fault_flag_low_o(flt), .fault_flag_low_oe_o(flt_oe),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    // {high, low} per bridge
    task gates(input logic [3:0] ea, input logic [3:0] eb);
        chk("gates_a", 32'(ea), 32'({ah, al}));
        chk("gates_b", 32'(eb), 32'({bh, bl}));
    endtask
    // sample at the falling edge, where outputs have settled
    task wt(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n = 0;
        @(posedge mclk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (ack !== 1'b1) begin
            chk("wb_ack", 32'h1, 32'(ack));
            summarize();
        end
    endtask
    function automatic logic [3:0] dec(input logic [1:0] c);
        case (c)
            2'b00: dec = 4'b0000;
            2'b01: dec = 4'b1001;
            2'b10: dec = 4'b0110;
            default: dec = 4'b0011;
        endcase
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs();
        wb(1'b1, ADDR_ENABLE, 32'h1f); // sel0 low, ignored
        wb_sel <= 4'hf;
        wb(1'b0, ADDR_ENABLE, 32'h0);
        chk("enable_rst", 32'(ENABLE_RST), q);
        wb(1'b0, ADDR_STATE, 32'h0);
        chk("state", 32'h2, q);
        wb(1'b1, 4'h6, 32'h1f);
        wb(1'b0, 4'h6, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b1, ADDR_STATUS, 32'h1f);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_ro", 32'h0, q);
    endtask
    task t_decode();
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk_i);
            lvl_a <= 2'(c);
            lvl_b <= 2'(c) ^ 2'b11;
            wt(40);
            gates(dec(2'(c)), dec(2'(c) ^ 2'b11));
        end
    endtask
    task automatic t_pwm(input logic [1:0] lvl, input logic sel, input logic [3:0] alt);
        int nf = 0;
        int na = 0;
        @(posedge mclk_i);
        lvl_a <= lvl;
        pwm_sel <= sel;
        pwm_en <= 1'b1;
        repeat (200) begin
            @(negedge mclk_i);
            nf += int'({ah, al} === 4'b0110);
            na += int'({ah, al} === alt);
        end
        chk("pwm_drive", 32'h1, 32'(nf > 0));
        chk("pwm_decay", 32'h1, 32'(na > 0));
        @(posedge mclk_i);
        pwm_en <= 1'b0;
    endtask
    task t_chop();
        @(posedge mclk_i);
        lvl_a <= 2'b00;
        wt(40);
        @(posedge mclk_i);
        lvl_a <= 2'b10;
        sense <= 2'b01;
        repeat (8) @(posedge mclk_i);
        sense <= 2'b00;
        wt(10);
        gates(4'b0110, 4'b0000);
        @(posedge mclk_i);
        sense <= 2'b01;
        repeat (3) @(posedge mclk_i);
        sense <= 2'b00;
        wt(14);
        gates(4'b0011, 4'b0000);
        wt(60);
        gates(4'b0110, 4'b0000);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_chop", 32'h1, q);
        wb(1'b1, ADDR_ENABLE, 32'h1);
        wt(2);
        chk("irq_on", 32'h1, 32'(irq));
        wb(1'b1, ADDR_ENABLE, 32'h0);
        wt(2);
        chk("irq_masked", 32'h0, 32'(irq));
        wb(1'b1, ADDR_ENABLE, 32'h1);
        wb(1'b1, ADDR_CLEAR, 32'h1);
        wt(2);
        chk("irq_cleared", 32'h0, 32'(irq));
    endtask
    task t_oc();
        @(posedge mclk_i);
        lvl_b <= 2'b01;
        oc_hi <= 2'b01;
        repeat (10) @(posedge mclk_i);
        oc_hi <= 2'b00;
        wt(30);
        chk("fault_glitch", 32'h0, 32'(flt_oe));
        gates(4'b0110, 4'b1001);
        @(posedge mclk_i);
        oc_lo <= 2'b01;
        wt(40);
        gates(4'b0000, 4'b1001);
        chk("fault_oc", 32'h1, 32'(flt_oe));
        @(posedge mclk_i);
        oc_lo <= 2'b00;
        wt(40);
        chk("fault_retry", 32'h1, 32'(flt_oe));
        wt(90);
        gates(4'b0110, 4'b1001);
        chk("fault_end", 32'h0, 32'(flt_oe));
    endtask
    task t_temp();
        @(posedge mclk_i);
        temp <= 1'b1;
        wt(10);
        gates(4'b0000, 4'b0000);
        chk("fault_temp", 32'h1, 32'(flt_oe));
        @(posedge mclk_i);
        temp <= 1'b0;
        wt(40);
        chk("fault_cool", 32'h0, 32'(flt_oe));
        gates(4'b0110, 4'b1001);
    endtask
    task t_supply();
        @(posedge mclk_i);
        supply_low <= 1'b1;
        wt(10);
        gates(4'b0000, 4'b0000);
        chk("fault_uv", 32'h0, 32'(flt_oe));
        @(posedge mclk_i);
        supply_low <= 1'b0;
        wt(10);
        gates(4'b0000, 4'b0000);
        wt(40);
        gates(4'b0110, 4'b1001);
    endtask
    task t_sleep();
        @(posedge mclk_i);
        sleep_request_low <= 1'b0;
        wt(4);
        gates(4'b0000, 4'b0000);
        wt(260);
        @(posedge mclk_i);
        lvl_a <= 2'b01;
        wt(5);
        gates(4'b0000, 4'b0000);
        @(posedge mclk_i);
        sleep_request_low <= 1'b1;
        wt(12);
        gates(4'b0000, 4'b0000);
        wt(40);
        gates(4'b1001, 4'b1001);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        wt(40);
        t_regs();
        t_decode();
        t_pwm(2'b00, 1'b1, 4'b0000);
        t_pwm(2'b10, 1'b0, 4'b0011);
        t_chop();
        t_oc();
        t_temp();
        t_supply();
        t_sleep();
        summarize();
    end
endmodule
bind bridge_ctrl bridge_ctrl_asserts bridge_ctrl_asserts_inst (.mclk_i, .reset_i, .sleep_request_low_i,
    .overcurrent_high_i, .overcurrent_low_i, .over_temp_i, .supply_low_lockout_i, .wb_cyc_i, .wb_stb_i,
    .bridge_a_high_on_o, .bridge_a_low_on_o, .bridge_b_high_on_o, .bridge_b_low_on_o, .fault_flag_low_o,
    .fault_flag_low_oe_o, .wb_ack_o);
